// ==== hdl/icm_capture_mode.sv ====
`timescale 1ns/1ps

// Functional notes
// - mode zero: channel off, no events
// - mode one: event on every edge
// - mode two: capture every falling edge
// - mode three: capture every rising edge
// - mode four: capture every fourth rising edge
// - mode five: capture every sixteenth rising edge
// - mode six: chosen edge first, then every edge
// - mode seven: interrupt only, sleep or idle
module icm_capture_mode (
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire icm_pkg::icm_cfg_t          cfg,
	input  wire logic                       lowPower,
	input  wire icm_pkg::icm_timers_t       timers,
	input  wire logic                       capturePin,
	output logic [icm_pkg::TIMER_W-1:0]     captureValue,
	output logic                            captureStrobe,
	output logic                            interruptReq
);
	import icm_pkg::*;

	// ****************************************
	// pin synchroniser
	// ****************************************
	// the pin is asynchronous to clock: two flops before any logic reads it
	// costs two cycles of latency, so pulses under one cycle may be lost
	logic syncA_reg, syncA_next;
	logic syncB_reg, syncB_next;
	logic last_reg,  last_next;

	always_comb begin
		syncA_next = capturePin;
		syncB_next = syncA_reg;
		last_next  = syncB_reg;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			syncA_reg <= 1'b0;
			syncB_reg <= 1'b0;
			last_reg  <= 1'b0;
		end else begin
			syncA_reg <= syncA_next;
			syncB_reg <= syncB_next;
			last_reg  <= last_next;
		end
	end

	// ****************************************
	// edge qualification
	// ****************************************
	// last_reg resets low like the idle pin, so no false edge after reset
	// a pin held high through reset shows one rising edge on release
	logic riseEdge;
	logic fallEdge;
	assign riseEdge = syncB_reg & ~last_reg;
	assign fallEdge = ~syncB_reg & last_reg;

	// ****************************************
	// helpers
	// ****************************************
	// edge-detect, first-edge and interrupt-only modes react to both edges
	function automatic logic anyEdge(
		input logic rise,
		input logic fall
	);
		return rise | fall;
	endfunction

	// prescaler advance; wraps to zero after the capturing edge
	function automatic logic [3:0] prescStep(
		input logic [3:0] count,
		input logic [3:0] last
	);
		logic [3:0] stepped;
		stepped = count + 4'h1;
		if (count == last) begin
			return PRESC_RESET;
		end
		return stepped;
	endfunction

	// timer chosen by the configuration in the cycle of the edge
	function automatic logic [TIMER_W-1:0] pickTimer(
		input logic        sel,
		input icm_timers_t t
	);
		if (sel) begin
			return t.timerB;
		end
		return t.timerA;
	endfunction

	// ****************************************
	// mode logic
	// ****************************************
	// mode_reg lags cfg by one cycle; the cycle of a change is spent
	// clearing the prescaler and the first-edge wait, edges there are lost
	// software is expected to leave a cycle after switching the channel off
	logic [3:0]         presc_reg,   presc_next;
	logic               armed_reg,   armed_next;
	icm_mode_t          mode_reg,    mode_next;
	// qualified events handed to the result stage
	logic               doCapture;
	logic               doIrq;

	always_comb begin
		doCapture   = 1'b0;
		doIrq       = 1'b0;
		presc_next  = presc_reg;
		armed_next  = armed_reg;
		mode_next   = cfg.captureModeSelect;
		// a mode change restarts the prescaler and first-edge wait
		if (mode_reg != cfg.captureModeSelect) begin
			presc_next = PRESC_RESET;
			armed_next = 1'b0;
		end else begin
			unique case (mode_reg)
				MODE_OFF: begin
					presc_next = PRESC_RESET;
				end
				MODE_EDGE: begin
					doCapture = anyEdge(riseEdge, fallEdge);
				end
				MODE_FALL: begin
					doCapture = fallEdge;
				end
				MODE_RISE: begin
					doCapture = riseEdge;
				end
				MODE_RISE4: begin
					if (riseEdge) begin
						doCapture  = (presc_reg == PRESC4_LAST);
						presc_next = prescStep(presc_reg, PRESC4_LAST);
					end
				end
				MODE_RISE16: begin
					if (riseEdge) begin
						doCapture  = (presc_reg == PRESC16_LAST);
						presc_next = prescStep(presc_reg, PRESC16_LAST);
					end
				end
				MODE_FIRST: begin
					if (armed_reg) begin
						// once armed, polarity no longer matters
						doCapture = anyEdge(riseEdge, fallEdge);
					end else if (cfg.firstEdgeRising ? riseEdge : fallEdge) begin
						doCapture  = 1'b1;
						armed_next = 1'b1;
					end
				end
				MODE_IRQ_ONLY: begin
					// outside sleep or idle this mode does nothing
					doIrq = lowPower & anyEdge(riseEdge, fallEdge);
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			presc_reg <= PRESC_RESET;
			armed_reg <= 1'b0;
			mode_reg  <= MODE_OFF;
		end else begin
			presc_reg <= presc_next;
			armed_reg <= armed_next;
			mode_reg  <= mode_next;
		end
	end

	// ****************************************
	// capture result and interrupt request
	// ****************************************
	// the value holds between captures so software reads a stable count
	logic [TIMER_W-1:0] value_reg,  value_next;
	logic               strobe_reg, strobe_next;
	logic               irq_reg,    irq_next;

	always_comb begin
		value_next = value_reg;
		if (doCapture) begin
			value_next = pickTimer(cfg.timerSelect, timers);
		end
		// both pulses last one cycle; the next needs a new edge
		strobe_next = doCapture;
		irq_next    = doCapture | doIrq;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			value_reg  <= CAPTURE_RESET;
			strobe_reg <= 1'b0;
			irq_reg    <= 1'b0;
		end else begin
			value_reg  <= value_next;
			strobe_reg <= strobe_next;
			irq_reg    <= irq_next;
		end
	end

	// ****************************************
	// outputs, straight from flip-flops
	// ****************************************
	assign captureValue  = value_reg;
	assign captureStrobe = strobe_reg;
	assign interruptReq  = irq_reg;

endmodule

// ==== hdl/icm_pkg.sv ====
package icm_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int TIMER_W = 16;

	// ****************************************
	// reset values and counts
	// ****************************************
	localparam logic [3:0]         PRESC_RESET   = 4'h0;
	localparam logic [3:0]         PRESC4_LAST   = 4'h3;
	localparam logic [3:0]         PRESC16_LAST  = 4'hF;
	localparam logic [TIMER_W-1:0] CAPTURE_RESET = 16'h0000;

	// ****************************************
	// capture mode codes
	// ****************************************
	typedef enum logic [2:0] {
		MODE_OFF      = 3'b000,
		MODE_EDGE     = 3'b001,
		MODE_FALL     = 3'b010,
		MODE_RISE     = 3'b011,
		MODE_RISE4    = 3'b100,
		MODE_RISE16   = 3'b101,
		MODE_FIRST    = 3'b110,
		MODE_IRQ_ONLY = 3'b111
	} icm_mode_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		icm_mode_t captureModeSelect;
		logic      firstEdgeRising;
		logic      timerSelect;
	} icm_cfg_t;

	typedef struct packed {
		logic [TIMER_W-1:0] timerA;
		logic [TIMER_W-1:0] timerB;
	} icm_timers_t;

endpackage

// ==== testbench/icm_pin_model.sv ====
`timescale 1ns/1ps
module icm_pin_model (
	input  wire logic clock,
	output logic      pin
);
	initial pin = 1'b0;
	// gap of at least 1 cycle, shorter pulses may be lost
	task automatic toggle(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge clock);
			#1 pin = ~pin;
		end
	endtask
endmodule

// ==== testbench/icm_properties.sv ====
`timescale 1ns/1ps
module icm_properties (
	input wire logic                   clock,
	input wire logic                   rst,
	input wire icm_pkg::icm_cfg_t      cfg,
	input wire logic                   lowPower,
	input wire logic                   capturePin,
	input wire logic [15:0]            captureValue,
	input wire logic                   captureStrobe,
	input wire logic                   interruptReq
);
	import icm_pkg::*;
	logic [4:0] ph;
	logic [4:0] ok;
	icm_cfg_t   pc;
	// pin sampled 3 edges before the sampled pulse, after the two sync flops
	wire rise = ph[2] & ~ph[3];
	wire fall = ph[3] & ~ph[2];
	wire st = (&ok) & (cfg == pc);
	icm_mode_t m;
	assign m = cfg.captureModeSelect;
	always_ff @(posedge clock) begin
		ph <= {ph[3:0], capturePin};
		pc <= cfg;
		ok <= rst ? 5'h00 : {ok[3:0], cfg == pc};
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	off_quiet_a: assert property (st && m == MODE_OFF |-> !interruptReq)
		else $error("event while off");
	edge_both_a: assert property (st && m == MODE_EDGE |-> interruptReq == (rise | fall))
		else $error("edge mode event");
	fall_cap_a: assert property (st && m == MODE_FALL |-> captureStrobe == fall)
		else $error("falling capture");
	rise_cap_a: assert property (st && m == MODE_RISE |-> captureStrobe == rise)
		else $error("rising capture");
	presc_rise_a: assert property (m == MODE_RISE4 && captureStrobe |-> rise)
		else $error("prescaled capture off edge");
	presc16_rise_a: assert property (m == MODE_RISE16 && captureStrobe |-> rise)
		else $error("divide by sixteen capture off edge");
	first_any_a: assert property (st && m == MODE_FIRST && captureStrobe |-> rise | fall)
		else $error("first edge mode capture off edge");
	irq_only_a: assert property (m == MODE_IRQ_ONLY |-> !captureStrobe && (lowPower || !interruptReq))
		else $error("interrupt only mode");
	cap_irq_a: assert property (captureStrobe |-> interruptReq)
		else $error("capture without interrupt");
	value_hold_a: assert property (!captureStrobe |-> $stable(captureValue))
		else $error("value moved");
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	import icm_pkg::*;
	logic               clock, rst, lowPower, capturePin, captureStrobe, interruptReq;
	icm_cfg_t           cfg;
	icm_timers_t        timers, tOld;
	logic [TIMER_W-1:0] captureValue;
	int                 n_mismatch, comparisons;
	icm_capture_mode icm_capture_mode_inst (.clock(clock), .rst(rst), .cfg(cfg),
		.lowPower(lowPower), .timers(timers), .capturePin(capturePin),
		.captureValue(captureValue), .captureStrobe(captureStrobe), .interruptReq(interruptReq));
	icm_pin_model icm_pin_model_inst (.clock(clock), .pin(capturePin));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock)
		timers <= #1 rst ? 32'h0000FFFF : {timers.timerA + 16'h0001, timers.timerB - 16'h0003};
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// 32 pin toggles: 16 rising, 16 falling, pin ends low
	task automatic scen(input icm_mode_t md, input logic fe, sel, lp, input int ns, ni);
		int s = 0;
		int i = 0;
		@(posedge clock);
		#1 cfg = '{md, fe, sel};
		lowPower = lp;
		fork
			icm_pin_model_inst.toggle(32, 3);
			repeat (110) begin
				@(posedge clock);
				#2;
				if (captureStrobe === 1'b1) begin
					s++;
					check(captureValue, sel ? tOld.timerB : tOld.timerA);
				end
				i += (interruptReq === 1'b1);
				tOld = timers;
			end
		join
		if (ns >= 0) check(s, ns);
		check(i, ni);
		$display("test mode %0d done", md);
	endtask
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		cfg = '0;
		lowPower = 1'b0;
		tOld = 32'h0000FFFF;
		n_mismatch = 0;
		comparisons = 0;
		repeat (8) @(posedge clock);
		#1 rst = 1'b0;
		scen(MODE_OFF, 0, 0, 0, 0, 0);
		scen(MODE_EDGE, 0, 0, 0, -1, 32);
		scen(MODE_FALL, 0, 1, 0, 16, 16);
		scen(MODE_RISE, 0, 0, 0, 16, 16);
		scen(MODE_RISE4, 0, 0, 0, 4, 4);
		scen(MODE_RISE16, 0, 1, 0, 1, 1);
		scen(MODE_FIRST, 0, 0, 0, 31, 31);
		scen(MODE_FIRST, 1, 0, 0, 32, 32);
		scen(MODE_IRQ_ONLY, 0, 0, 1, 0, 32);
		scen(MODE_IRQ_ONLY, 0, 0, 0, 0, 0);
		end_sim;
	end
endmodule
bind icm_capture_mode icm_properties icm_properties_inst (.clock(clock), .rst(rst), .cfg(cfg),
	.lowPower(lowPower), .capturePin(capturePin), .captureValue(captureValue),
	.captureStrobe(captureStrobe), .interruptReq(interruptReq));
